// >>> rtl/eisc_ctrl.sv
// External interrupt sensitivity control: two sense registers, five line latches, APB slave, event status.
// Assumes the CPU drives the global mask level and isr entry pulses on ref_clk; pins are asynchronous.
// Notes on behaviour
// [RULE1] Second sense register clears to zero on reset
// [RULE2] Software writes zeros to second register upper bits
// [RULE3] Second register bits 3:2 select line four
// [RULE4] Second register bits 1:0 select line three
// [RULE5] Sense writes accepted only while global mask set
// [RULE6] Changing a line's sense drops its pending request
// [RULE7] Software should give line four rising-edge-only; the code accepts and acts on all four codes for line four
// [RULE8] Registers at indices 37h and 3Dh, reset zero
// [RULE9] Codes: fall+low, rise, fall, both edges
// [RULE10] Edge requests latched, cleared on service entry
// [RULE11] First register: line two, one, zero fields
// [RULE12] Refused writes leave register contents unchanged
`timescale 1ns/1ps
module eisc_ctrl
    import eisc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [EISC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU side
    input wire logic glb_irq_mask,
    input wire logic [EISC_NLINES-1:0] isr_enter,
    output logic [EISC_NLINES-1:0] line_req,
    output logic irq,
    // External interrupt pins
    input wire logic ext_line_zero,
    input wire logic ext_line_one,
    input wire logic ext_line_two,
    input wire logic ext_line_three,
    input wire logic ext_line_four
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [1:0] sense_f(input logic [7:0] lo, input logic [7:0] hi, input int unsigned n);
        logic [1:0] r;
        r = EISC_SENSE_FALL_LOW;
        unique case (n)
            0: r = lo[EISC_L0_LSB +: 2]; // see [RULE11]
            1: r = lo[EISC_L1_LSB +: 2]; // see [RULE11]
            2: r = lo[EISC_L2_LSB +: 2]; // see [RULE11]
            3: r = hi[EISC_L3_LSB +: 2]; // see [RULE4]
            4: r = hi[EISC_L4_LSB +: 2]; // see [RULE3]
            default: r = EISC_SENSE_FALL_LOW;
        endcase
        return r;
    endfunction

    function automatic logic hit_f(input logic [1:0] s, input logic r, input logic f);
        logic h;
        h = 1'b0;
        unique case (s)
            EISC_SENSE_FALL_LOW: h = f; // see [RULE9]
            EISC_SENSE_RISE: h = r; // see [RULE9]
            EISC_SENSE_FALL: h = f; // see [RULE9]
            EISC_SENSE_BOTH: h = r | f; // see [RULE9]
        endcase
        return h;
    endfunction

    function automatic logic sel_f(input logic [EISC_ADDR_W-1:0] a, input logic [9:0] idx);
        return (a[EISC_ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] low_q;
    logic [7:0] high_q;
    logic [7:0] low_d;
    logic [7:0] high_d;
    logic [EISC_NEV-1:0] stat_q;
    logic [EISC_NEV-1:0] mask_q;
    logic [EISC_NLINES-1:0] pin_raw;
    logic [EISC_NLINES-1:0] s1_q;
    logic [EISC_NLINES-1:0] s2_q;
    logic [EISC_NLINES-1:0] s3_q;
    logic [EISC_NLINES-1:0] lat_q;
    logic [EISC_NLINES-1:0] edge_hit;
    logic [EISC_NLINES-1:0] lvl_act;
    logic [EISC_NLINES-1:0] chg;
    logic [31:0] prdata_q;
    logic wr_acc;
    logic sel_low;
    logic sel_high;
    logic sel_stat;
    logic sel_mask;
    logic hit_any;
    logic sense_wr;
    logic wr_low_ok;
    logic wr_high_ok;
    logic refused;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign sel_low = sel_f(paddr, EISC_IDX_LOW); // see [RULE8]
    assign sel_high = sel_f(paddr, EISC_IDX_HIGH); // see [RULE8]
    assign sel_stat = sel_f(paddr, EISC_IDX_STAT);
    assign sel_mask = sel_f(paddr, EISC_IDX_MASK);
    assign hit_any = sel_low | sel_high | sel_stat | sel_mask;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign wr_acc = psel & penable & pwrite & pready & hit_any & pstrb[0];
    assign sense_wr = wr_acc & (sel_low | sel_high);
    assign wr_low_ok = wr_acc & sel_low & glb_irq_mask; // see [RULE5]
    assign wr_high_ok = wr_acc & sel_high & glb_irq_mask; // see [RULE5]
    assign refused = sense_wr & ~glb_irq_mask; // see [RULE12]
    assign prdata = prdata_q;

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= 32'h0;
            if (sel_low) begin
                prdata_q[7:0] <= low_q;
            end else if (sel_high) begin
                prdata_q[7:0] <= high_q;
            end else if (sel_stat) begin
                prdata_q[EISC_NEV-1:0] <= stat_q;
            end else if (sel_mask) begin
                prdata_q[EISC_NEV-1:0] <= mask_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sensitivity registers
    // ----------------------------------------------------------------
    // Reserved bits are not stored and read as zero
    always_comb begin
        low_d = wr_low_ok ? (pwdata[7:0] & EISC_LOW_WMASK) : low_q;
        high_d = wr_high_ok ? (pwdata[7:0] & EISC_HIGH_WMASK) : high_q; // see [RULE2]
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_q <= EISC_SENSE_RST; // see [RULE8]
            high_q <= EISC_SENSE_RST; // see [RULE1]
        end else begin
            low_q <= low_d; // see [RULE12]
            high_q <= high_d; // see [RULE12]
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    assign pin_raw = {ext_line_four, ext_line_three, ext_line_two, ext_line_one, ext_line_zero};

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= {EISC_NLINES{1'b1}};
            s2_q <= {EISC_NLINES{1'b1}};
            s3_q <= {EISC_NLINES{1'b1}};
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        for (int unsigned n = 0; n < EISC_NLINES; n++) begin
            edge_hit[n] = hit_f(sense_f(low_q, high_q, n), s2_q[n] & ~s3_q[n], ~s2_q[n] & s3_q[n]);
            lvl_act[n] = (sense_f(low_q, high_q, n) == EISC_SENSE_FALL_LOW) & ~s2_q[n]; // see [RULE9]
            chg[n] = sense_f(low_q, high_q, n) != sense_f(low_d, high_d, n); // see [RULE6]
        end
    end

    // ----------------------------------------------------------------
    // Request latches
    // ----------------------------------------------------------------
    // A new edge wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lat_q <= EISC_LINES_RST;
        end else begin
            lat_q <= edge_hit | (lat_q & ~isr_enter & ~chg); // see [RULE10] see [RULE6]
        end
    end

    assign line_req = lat_q | lvl_act;

    // ----------------------------------------------------------------
    // Event status, mask and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= EISC_EV_RST;
        end else begin
            stat_q <= {refused, edge_hit} | (stat_q & ~((wr_acc && sel_stat) ? pwdata[EISC_NEV-1:0] : EISC_EV_RST));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= EISC_EV_RST;
        end else if (wr_acc && sel_mask) begin
            mask_q <= pwdata[EISC_NEV-1:0];
        end
    end

    assign irq = |(stat_q & mask_q);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_reset_zero: assert property ($rose(rst_b) |-> (high_q == EISC_SENSE_RST) && (low_q == EISC_SENSE_RST)) // see [RULE1]
        else $error("sense registers not zero after reset");
    a_line4_field: assert property (wr_high_ok |=> sense_f(low_q, high_q, 4) == $past(pwdata[3:2])) // see [RULE3]
        else $error("line four sense not taken from bits 3:2");
    a_line3_field: assert property (wr_high_ok |=> sense_f(low_q, high_q, 3) == $past(pwdata[1:0])) // see [RULE4]
        else $error("line three sense not taken from bits 1:0");
    a_low_fields: assert property (wr_low_ok |=> low_q == ($past(pwdata[7:0]) & EISC_LOW_WMASK)) // see [RULE11]
        else $error("first register fields not stored");
    a_write_gated: assert property (psel && penable && pwrite && sel_high && pstrb[0] && glb_irq_mask
        |=> high_q == ($past(pwdata[7:0]) & EISC_HIGH_WMASK)) // see [RULE5]
        else $error("write with mask set not accepted");
    a_write_refused: assert property (refused |=> $stable(high_q) && $stable(low_q) && stat_q[EISC_EV_REFUSED]) // see [RULE12]
        else $error("refused write changed a register");
    a_change_drop: assert property (|(chg & ~edge_hit) |=> (lat_q & $past(chg & ~edge_hit)) == EISC_LINES_RST) // see [RULE6]
        else $error("pending request survived sense change");
    a_isr_clear: assert property (|(isr_enter & ~edge_hit) |=> (lat_q & $past(isr_enter & ~edge_hit)) == EISC_LINES_RST) // see [RULE10]
        else $error("latched request not cleared on isr entry");
    a_rise_latch: assert property (sense_f(low_q, high_q, 0) == EISC_SENSE_RISE && s2_q[0] && !s3_q[0]
        |=> lat_q[0] && line_req[0]) // see [RULE9]
        else $error("rising edge not latched");
    a_level_req: assert property (sense_f(low_q, high_q, 1) == EISC_SENSE_FALL_LOW && !s2_q[1] |-> line_req[1]) // see [RULE9]
        else $error("low level not requesting");
    a_read_map: assert property (psel && !penable && !pwrite && sel_high ##1 psel && penable
        |-> prdata == {24'h0, high_q}) // see [RULE8]
        else $error("second register read wrong");

    c_sense_write: cover property (wr_high_ok ##1 chg == EISC_LINES_RST);
    c_refused: cover property (refused);
    c_edge_then_isr: cover property (edge_hit[4] ##[1:20] isr_enter[4]);
    c_irq: cover property ($rose(irq));
    c_level_low: cover property (lvl_act[0]);

    // ----------------------------------------------------------------
    // Bus response
    // ----------------------------------------------------------------
    // Zero wait states: every access phase ends in one cycle
    a_ready_high: assert property (pready) // see [RULE8]
        else $error("pready not high");
    a_slverr_unmap: assert property (psel && penable && !hit_any |-> pslverr) // see [RULE8]
        else $error("unmapped access without error");
    a_slverr_mapped: assert property (psel && penable && hit_any |-> !pslverr) // see [RULE8]
        else $error("mapped access flagged as error");
    a_slverr_idle: assert property (!(psel && penable) |-> !pslverr) // see [RULE8]
        else $error("error outside access phase");
    a_read_low: assert property (psel && !penable && !pwrite && sel_low ##1 psel && penable
        |-> prdata == {24'h0, low_q}) // see [RULE11]
        else $error("first register read wrong");
    a_prdata_upper: assert property (prdata[31:8] == 24'h0) // see [RULE8]
        else $error("read data upper bits not zero");
    a_strobe_gate: assert property (psel && penable && pwrite && !pstrb[0]
        |=> $stable(high_q) && $stable(low_q)) // see [RULE12]
        else $error("write without byte strobe changed a register");

    // ----------------------------------------------------------------
    // Register contents
    // ----------------------------------------------------------------
    a_high_reserved: assert property (high_q[7:4] == 4'h0) // see [RULE2]
        else $error("second register reserved bits set");
    a_low_reserved: assert property (low_q[7:6] == 2'h0) // see [RULE11]
        else $error("first register reserved bits set");
    a_low_gated: assert property (wr_acc && sel_low && !glb_irq_mask |=> $stable(low_q)) // see [RULE5]
        else $error("first register written with mask clear");
    a_high_gated: assert property (wr_acc && sel_high && !glb_irq_mask |=> $stable(high_q)) // see [RULE5]
        else $error("second register written with mask clear");
    a_hold_idle: assert property (!wr_acc |=> $stable(low_q) && $stable(high_q)) // see [RULE12]
        else $error("register changed without a write");
    a_low_accept: assert property (psel && penable && pwrite && sel_low && pstrb[0] && glb_irq_mask
        |=> low_q == ($past(pwdata[7:0]) & EISC_LOW_WMASK)) // see [RULE5]
        else $error("first register write with mask set not accepted");
    a_lat_reset: assert property ($rose(rst_b) |-> lat_q == EISC_LINES_RST && !irq) // see [RULE1]
        else $error("latches or interrupt not clear after reset");

    // ----------------------------------------------------------------
    // Requests
    // ----------------------------------------------------------------
    a_fall_latch: assert property (sense_f(low_q, high_q, 1) == EISC_SENSE_FALL && !s2_q[1] && s3_q[1]
        |=> lat_q[1]) // see [RULE9]
        else $error("falling edge not latched");
    a_both_latch: assert property (sense_f(low_q, high_q, 3) == EISC_SENSE_BOTH && (s2_q[3] != s3_q[3])
        |=> lat_q[3]) // see [RULE9]
        else $error("edge not latched in both-edge mode");
    a_rise_ignore: assert property (sense_f(low_q, high_q, 2) == EISC_SENSE_RISE && !s2_q[2] && s3_q[2]
        && !lat_q[2] |=> !lat_q[2]) // see [RULE9]
        else $error("falling edge latched in rising mode");
    a_fall_ignore: assert property (sense_f(low_q, high_q, 4) == EISC_SENSE_FALL && s2_q[4] && !s3_q[4]
        && !lat_q[4] |=> !lat_q[4]) // see [RULE9]
        else $error("rising edge latched in falling mode");
    a_level_high: assert property (sense_f(low_q, high_q, 0) == EISC_SENSE_FALL_LOW && s2_q[0] && !lat_q[0]
        |-> !line_req[0]) // see [RULE9]
        else $error("high level requesting");
    a_edge_hold: assert property (|(lat_q & ~isr_enter & ~chg)
        |=> (lat_q & $past(lat_q & ~isr_enter & ~chg)) == $past(lat_q & ~isr_enter & ~chg)) // see [RULE10]
        else $error("latched request lost without cause");

    // ----------------------------------------------------------------
    // Events and interrupt
    // ----------------------------------------------------------------
    a_status_edge: assert property (|edge_hit
        |=> (stat_q[EISC_NLINES-1:0] & $past(edge_hit)) == $past(edge_hit)) // see [RULE10]
        else $error("edge event not recorded");
    a_status_clear: assert property (wr_acc && sel_stat && pwdata[EISC_EV_REFUSED]
        |=> !stat_q[EISC_EV_REFUSED]) // see [RULE12]
        else $error("refused flag not cleared by write one");
    a_status_sticky: assert property (stat_q[EISC_EV_REFUSED] && !(wr_acc && sel_stat)
        |=> stat_q[EISC_EV_REFUSED]) // see [RULE12]
        else $error("refused flag dropped without clear");
    a_mask_store: assert property (wr_acc && sel_mask
        |=> mask_q == $past(pwdata[EISC_NEV-1:0])) // see [RULE10]
        else $error("mask write not stored");
    a_irq_quiet: assert property (mask_q == EISC_EV_RST |-> !irq) // see [RULE10]
        else $error("interrupt raised with all events masked");

endmodule // eisc_ctrl

// >>> rtl/eisc_pkg.sv
// Constants for the external interrupt sensitivity control block.
// Assumes a 32-bit APB with byte addresses; each register sits at four times its index.
package eisc_pkg;
    // ----------------------------------------------------------------
    // Register indices and map
    // ----------------------------------------------------------------
    localparam int unsigned EISC_ADDR_W = 12;
    localparam logic [9:0] EISC_IDX_LOW = 10'h037;
    localparam logic [9:0] EISC_IDX_HIGH = 10'h03d;
    localparam logic [9:0] EISC_IDX_STAT = 10'h040;
    localparam logic [9:0] EISC_IDX_MASK = 10'h041;
    localparam logic [7:0] EISC_SENSE_RST = 8'h00;
    localparam logic [7:0] EISC_LOW_WMASK = 8'h3f;
    localparam logic [7:0] EISC_HIGH_WMASK = 8'h0f;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned EISC_L0_LSB = 0;
    localparam int unsigned EISC_L1_LSB = 2;
    localparam int unsigned EISC_L2_LSB = 4;
    localparam int unsigned EISC_L3_LSB = 0;
    localparam int unsigned EISC_L4_LSB = 2;

    // ----------------------------------------------------------------
    // Lines, events and sensitivity codes
    // ----------------------------------------------------------------
    localparam int unsigned EISC_NLINES = 5;
    localparam int unsigned EISC_NEV = 6;
    localparam int unsigned EISC_EV_REFUSED = 5;
    localparam logic [EISC_NEV-1:0] EISC_EV_RST = 6'h00;
    localparam logic [EISC_NLINES-1:0] EISC_LINES_RST = 5'h00;
    localparam logic [1:0] EISC_SENSE_FALL_LOW = 2'h0;
    localparam logic [1:0] EISC_SENSE_RISE = 2'h1;
    localparam logic [1:0] EISC_SENSE_FALL = 2'h2;
    localparam logic [1:0] EISC_SENSE_BOTH = 2'h3;
endpackage

// >>> verification/eisc_partner.sv
// Partner model: the five external pins and a CPU that enters service routines.
// Assumes the bench sets pin levels and the service enable right after rising edges of ref_clk.
`timescale 1ns/1ps
module eisc_partner
    import eisc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Bench control
    input wire logic [EISC_NLINES-1:0] pin_lvl,
    input wire logic svc_en,
    // Device side
    input wire logic [EISC_NLINES-1:0] line_req,
    output logic [EISC_NLINES-1:0] isr_enter,
    output logic [EISC_NLINES-1:0] pins
);
    // One-cycle entry pulse for each pending request while servicing
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            isr_enter <= EISC_LINES_RST;
        end else begin
            isr_enter <= (svc_en ? line_req : EISC_LINES_RST) & ~isr_enter;
        end
    end
    assign pins = pin_lvl;
endmodule // eisc_partner

// >>> verification/ext_irq_sense_control_test.sv
// Testbench: APB master, pin stimulus through the partner, expectations from functions.
// Assumes a zero-wait APB slave with status at 0x100 and mask at 0x104.
`timescale 1ns/1ps
module ext_irq_sense_control_test
    import eisc_pkg::*;
;
    localparam logic [EISC_ADDR_W-1:0] A_LO = {EISC_IDX_LOW, 2'b00};
    localparam logic [EISC_ADDR_W-1:0] A_HI = {EISC_IDX_HIGH, 2'b00};
    localparam logic [EISC_ADDR_W-1:0] A_ST = {EISC_IDX_STAT, 2'b00};
    localparam logic [EISC_ADDR_W-1:0] A_MK = {EISC_IDX_MASK, 2'b00};
    logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, glb_irq_mask = 0, svc_en = 0;
    logic [EISC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = '0, strb = 4'hf;
    logic pready, pslverr, irq, err;
    logic [EISC_NLINES-1:0] line_req, isr_enter, pins, pin_lvl = '1;
    logic [7:0] lfsr = 8'h27, lo = 8'h00, hi = 8'h00;
    int errors = 0, n_tests = 0, cyc = 0;

    eisc_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .glb_irq_mask(glb_irq_mask), .isr_enter(isr_enter), .line_req(line_req), .irq(irq),
        .ext_line_zero(pins[0]), .ext_line_one(pins[1]), .ext_line_two(pins[2]),
        .ext_line_three(pins[3]), .ext_line_four(pins[4]));
    eisc_partner cpu (.ref_clk(ref_clk), .rst_b(rst_b), .pin_lvl(pin_lvl), .svc_en(svc_en),
        .line_req(line_req), .isr_enter(isr_enter), .pins(pins));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] next_rand(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic fall_hit(logic [1:0] c);
        return c != EISC_SENSE_RISE;
    endfunction
    function automatic logic rise_hit(logic [1:0] c);
        return c == EISC_SENSE_RISE || c == EISC_SENSE_BOTH;
    endfunction
    task automatic give_verdict();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [EISC_ADDR_W-1:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wt(int k);
        repeat (k) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic set_sense(int n, logic [1:0] c);
        if (n < 3) begin
            lo[2*n+:2] = c;
            apb(1, A_LO, {24'h0, lo});
        end else begin
            hi[2*(n-3)+:2] = c;
            apb(1, A_HI, {24'h0, hi});
        end
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1;
        apb(0, A_LO, 0);
        chk("low reset", rd, 0);
        chk("mapped err", err, 0);
        chk("ready", pready, 1);
        apb(0, A_HI, 0);
        chk("high reset", rd, 0);
        apb(0, 12'h0e0, 0);
        chk("unmapped err", err, 1);
        apb(1, A_HI, 32'h0f);
        apb(0, A_HI, 0);
        chk("refused write", rd, 0);
        apb(0, A_ST, 0);
        chk("refused status", rd, 32'h20);
        wt(1);
        chk("irq masked", irq, 0);
        apb(1, A_MK, 32'h20);
        wt(1);
        chk("irq raised", irq, 1);
        apb(1, A_ST, 32'h20);
        wt(1);
        chk("irq cleared", irq, 0);
        @(posedge ref_clk) glb_irq_mask <= 1;
        strb = 4'h0;
        apb(1, A_LO, 32'h15);
        strb = 4'hf;
        apb(0, A_LO, 0);
        chk("strobe ignored", rd, {24'h0, lo});
        repeat (8) begin
            lfsr = next_rand(lfsr);
            apb(1, A_LO, {24'h0, lfsr & EISC_LOW_WMASK});
            apb(1, A_HI, {24'h0, lfsr & EISC_HIGH_WMASK});
            apb(0, A_LO, 0);
            chk("low rw", rd, {24'h0, lfsr & EISC_LOW_WMASK});
            apb(0, A_HI, 0);
            chk("high rw", rd, {24'h0, lfsr & EISC_HIGH_WMASK});
            lo = lfsr & EISC_LOW_WMASK;
            hi = lfsr & EISC_HIGH_WMASK;
        end
        for (int n = 0; n < EISC_NLINES; n++) begin
            for (int c = 0; c < 4; c++) begin
                set_sense(n, c[1:0]);
                apb(1, A_ST, 32'h3f);
                pin_lvl[n] <= 0;
                wt(5);
                apb(0, A_ST, 0);
                chk("fall status", rd[n], fall_hit(c[1:0]));
                chk("fall req", line_req[n], fall_hit(c[1:0]));
                @(posedge ref_clk) svc_en <= 1;
                wt(5);
                chk("serviced", line_req[n], c == 0);
                @(posedge ref_clk) svc_en <= 0;
                apb(1, A_ST, 32'h3f);
                pin_lvl[n] <= 1;
                wt(5);
                apb(0, A_ST, 0);
                chk("rise status", rd[n], rise_hit(c[1:0]));
                chk("rise req", line_req[n], rise_hit(c[1:0]));
                set_sense(n, c[1:0] ^ 2'h1);
                wt(2);
                chk("sense drop", line_req[n], 0);
            end
        end
        set_sense(4, EISC_SENSE_RISE);
        apb(0, A_HI, 0);
        chk("line four rise", rd[3:2], EISC_SENSE_RISE);
        give_verdict();
    end
endmodule // ext_irq_sense_control_test
